// ==== tb/spm_peer_model.sv ====
// Purpose: External slave on the four-wire bus for master runs
// Assumes: Capture on rising edge at either idle level, MSB first
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module spm_peer_model (
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output logic            miso
);
    logic [7:0] sh;
    int         cnt;
    // First bit sits on the line as soon as we are selected
    always @(negedge cs_n) begin
        sh = tx_byte;
        cnt = 0;
        miso = tx_byte[7];
    end
    // No pull on this line, so a stale bit must not look valid
    always @(posedge cs_n) miso = ~miso;
    // Sample on rising, present next bit on the following fall
    always @(posedge sck) if (!cs_n) begin
        rx_byte = {rx_byte[6:0], mosi};
        cnt++;
    end
    always @(negedge sck) if (!cs_n && cnt > 0) begin
        sh = sh << 1;
        miso = sh[7];
    end
    initial rx_byte = 8'h00;
endmodule : spm_peer_model

// ==== tb/spm_port_asserts.sv ====
// Purpose: Port-level checks on the serial peripheral port
// Assumes: Sees only the top module's ports
// Notes:   Frame length is counted on the driven clock pin
`timescale 1ns/1ps
module spm_port_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic irq,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic cs_n_o,
    input wire logic cs_n_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] edge_cnt;
    logic       sck_q;
    // Count clock edges while the select is driven low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt <= 5'h00;
            sck_q    <= 1'h0;
        end else begin
            sck_q    <= sck_o;
            edge_cnt <= (cs_n_o || !cs_n_oe) ? 5'h00
                        : edge_cnt + 5'(sck_o != sck_q);
        end
    end
    // Enable gating on both ends avoids false hits when the pin is taken
    sequence frame_start;
        cs_n_oe && $past(cs_n_oe) && $fell(cs_n_o);
    endsequence
    sequence frame_end;
        cs_n_oe && $past(cs_n_oe) && $rose(cs_n_o);
    endsequence
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    sel_lead_a: assert property (frame_start |-> $stable(sck_o) [*2])
        else $error("clock moved with select");
    frame_len_a: assert property (frame_end |->
        edge_cnt + 5'(sck_o != sck_q) == 5'h10)
        else $error("frame edge count wrong");
    sck_idle_a: assert property (
        (cs_n_oe && cs_n_o && !psel) [*3] |-> $stable(sck_o))
        else $error("clock moved while idle");
    sdo_idle_a: assert property (
        (sdo_oe && cs_n_oe && cs_n_o) [*3] |-> sdo_o)
        else $error("output line not high while idle");
    clk_owner_a: assert property (cs_n_oe |-> sck_oe)
        else $error("select driven without clock");
    irq_hold_a: assert property ($fell(irq) |->
        $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("completion dropped without a write");
endmodule : spm_port_asserts

bind spm_port spm_port_asserts u_spm_port_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .irq(irq), .sck_o(sck_o),
    .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cs_n_o(cs_n_o),
    .cs_n_oe(cs_n_oe));

// ==== tb/spm_port_tb_top.sv ====
// Purpose: Self-checking bench for the serial peripheral port
// Assumes: 40 MHz pclk; 200 ns link clock built on pclk edges
// Notes:   Master runs talk to a peer model, slave runs to the bench
`timescale 1ns/1ps
module spm_port_tb_top;
    typedef struct packed {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] exp;
        logic        err;
    } spm_row_type;
    localparam logic [11:0] C0 = spm_pkg::CTRL0_OFFSET;
    localparam logic [11:0] C1 = spm_pkg::CTRL1_OFFSET;
    localparam logic [11:0] DA = spm_pkg::DATA_OFFSET;
    localparam spm_row_type ROWS [6] = '{
        '{C0, 32'hE1, C0, 32'hE1, 1'h0}, '{C0, 32'hE1, C1, 32'h00, 1'h0},
        '{C1, 32'hFFFF_FFFF, C1, 32'h3F, 1'h0},
        '{C1, 32'h00, C1, 32'h00, 1'h0}, '{C0, 32'h00, C0, 32'h00, 1'h0},
        '{12'h00C, 32'hFF, 12'h00C, 32'h00, 1'h1}};
    logic        pclk, presetn, psel, penable, pwrite, master, e;
    logic        tb_sck, tb_cs, tb_sdi, pready, pslverr, irq, miso;
    logic        sck_o, sck_oe, sdo_o, sdo_oe, cs_n_o, cs_n_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  peer_rx, got;
    int          err_count, samples_checked;
    wire         sck_w = sck_oe ? sck_o : tb_sck;
    wire         cs_w = cs_n_oe ? cs_n_o : tb_cs;
    always #12.5 pclk = ~pclk;
    spm_port u_spm_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
        .sdi_i(master ? miso : tb_sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .cs_n_i(cs_w), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe));
    spm_peer_model u_spm_peer_model (.sck(sck_w), .cs_n(cs_w),
        .mosi(sdo_o), .tx_byte(8'h5A), .rx_byte(peer_rx), .miso(miso));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // Request held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Ready, read data and error are taken at the edge they are seen
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            err_count++;
            end_sim();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, rd);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] want);
        apb(1'h0, a, 32'h0, rd);
        chk(rd, want);
    endtask : rc
    // Bounded wait for the completion interrupt; a timeout ends the run
    task automatic wait_irq;
        for (int n = 0; n < 4000 && irq !== 1'h1; n++) begin
            @(posedge pclk);
        end
        chk(32'(irq), 32'h1);
        if (irq !== 1'h1) begin
            end_sim();
        end
    endtask : wait_irq
    // Bench as external master: LSB first, clock stands still between frames
    task automatic slv_frame(input logic [7:0] b, input int nb);
        tb_cs <= 1'h0;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            tb_sck <= 1'h0;
            tb_sdi <= b[i];
            repeat (4) @(posedge pclk);
            got[i] = sdo_o;
            tb_sck <= 1'h1;
            repeat (4) @(posedge pclk);
        end
        tb_cs <= 1'h1;
        tb_sdi <= ~tb_sdi;
        repeat (8) @(posedge pclk);
    endtask : slv_frame
    initial begin
        {pclk, presetn, psel, penable, pwrite, master} = 6'h00;
        {tb_sck, tb_cs, tb_sdi, paddr, pwdata} = {3'h6, 44'h0};
        {err_count, samples_checked, got} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        rc(C1, 32'h0);
        chk(32'({sck_oe, sdo_oe, cs_n_oe}), 32'h0);
        foreach (ROWS[i]) begin
            wr(ROWS[i].wa, ROWS[i].wd);
            rc(ROWS[i].ra, ROWS[i].exp);
            chk(32'(e), 32'(ROWS[i].err));
        end
        $display("register table test done");
        master <= 1'h1;
        wr(C1, 32'h0C);
        wr(C0, 32'h22);
        @(posedge pclk);
        chk(32'({sck_oe, sck_o, sdo_oe, sdo_o}), 32'hF);
        wr(DA, 32'hA5);
        wr(DA, 32'h3C);
        wait_irq();
        chk(32'(peer_rx), 32'hA5);
        rc(DA, 32'h5A);
        rc(C1, 32'h0F);
        wr(C1, 32'h0C);
        rc(C1, 32'h0C);
        chk(32'(irq), 32'h0);
        // Idle-low clock capturing on rising edges
        wr(C1, 32'h3C);
        wr(DA, 32'hC3);
        wait_irq();
        chk(32'(peer_rx), 32'hC3);
        rc(DA, 32'h5A);
        repeat (16) @(posedge pclk);
        chk(32'(sck_o), 32'h0);
        $display("master transfer test done");
        master <= 1'h0;
        wr(C1, 32'h04);
        wr(C0, 32'h82);
        wr(DA, 32'h96);
        chk(32'(sck_oe), 32'h0);
        slv_frame(8'h3C, 8);
        chk(32'(got), 32'h96);
        rc(DA, 32'h3C);
        rc(C1, 32'h05);
        wr(C1, 32'h04);
        slv_frame(8'hFF, 3);
        rc(C0, 32'h83);
        rc(C1, 32'h05);
        wr(C0, 32'h00);
        repeat (2) @(posedge pclk);
        chk(32'({sck_oe, sdo_oe, cs_n_oe}), 32'h0);
        $display("slave transfer test done");
        end_sim();
    end
endmodule : spm_port_tb_top

// ==== verilog/spm_pkg.sv ====
// Purpose: Shared constants and state type of the serial peripheral port
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Control bits live in the low byte; upper bits read as zero
package spm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] CTRL0_OFFSET = 12'h000;
    localparam logic [11:0] CTRL1_OFFSET = 12'h004;
    localparam logic [11:0] DATA_OFFSET  = 12'h008;

    // Field positions, port_control_0
    localparam int C0_MODE_LSB = 5;
    localparam int C0_EN_BIT   = 1;
    localparam int C0_ICF_BIT  = 0;
    // Field positions, port_control_1
    localparam int C1_POL_BIT  = 5;
    localparam int C1_EDGE_BIT = 4;
    localparam int C1_MSB_BIT  = 3;
    localparam int C1_CSEN_BIT = 2;
    localparam int C1_WCOL_BIT = 1;
    localparam int C1_TRF_BIT  = 0;

    // Reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;

    // ****************************************************************
    // Timing and framing
    // ****************************************************************
    // Shortest master half period in pclk cycles; grows 4x per step
    localparam logic [7:0] HALF_BASE   = 8'h02;
    localparam logic [3:0] LAST_BIT    = 4'h7;
    localparam logic [4:0] LAST_EDGE   = 5'h0F;
    // Mode field values with the top bit set select slave operation
    localparam int         MODE_SLAVE_BIT = 2;

    // ****************************************************************
    // Whole state of the port
    // ****************************************************************
    typedef struct packed {
        logic [2:0]  mode;
        logic        en;
        logic        icf;
        logic        pol;
        logic        edge_sel;
        logic        msb;
        logic        csen;
        logic        wcol;
        logic        trf;
        logic [7:0]  data;
        logic [7:0]  tx;
        logic [7:0]  rx;
        logic [3:0]  bits;
        logic [4:0]  edges;
        logic [7:0]  div;
        logic        run;
        logic        have_cap;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic        sck_last;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        sck_o;
        logic        sck_oe;
        logic        sdo_o;
        logic        sdo_oe;
        logic        cs_o;
        logic        cs_oe;
    } spm_state_type;

endpackage : spm_pkg

// ==== verilog/spm_port.sv ====
// Purpose: Four-line synchronous serial port, master or slave, APB slave
// Assumes: pclk far faster than the link clock; pins pass two flip-flops
// Notes:   Operation
// Operation
// - Data write during a transfer sets the write collision flag
// - Such a write is discarded; the shifting byte stays unchanged
// - Collision flag stays set until software clears it
// - Completion flag set at transfer end, held until software clears
// - Set completion flag drives the interrupt request output
// - Master and enabled: data write starts a full-duplex transfer
// - Slave: external clock edges shift data out and in
// - Select goes active before the first clock; slave data ready then
// - Port keeps working in idle states while its clock runs
// - Enabled with select enabled and idle: input floats, output high; a deselected slave here releases the output instead
// - Idle master clock sits at idle polarity; slave clock floats
// - Port disabled: all four lines released
// - Master makes the clock; slave takes it only from the master
// - Select pin enable decides whether select controls the port
// - Received bits build in a buffer, copied whole into data register
// - Both ends must use the same bit order
// - Every transfer uses select, clock, input and output lines; here select goes unused while select enable is clear
// - Slave deselected mid-byte sets incomplete and completion flags
// - Polarity and edge select choose idle level and capture edge
// - Bit order select: 1 gives MSB first, 0 LSB first
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps

module spm_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe,
    input  wire logic        cs_n_i,
    output logic             cs_n_o,
    output logic             cs_n_oe
);

    // ****************************************************************
    // State and decode
    // ****************************************************************
    spm_pkg::spm_state_type state_reg;
    spm_pkg::spm_state_type state_next;

    logic       slave;
    logic       sel;
    logic       busy;
    logic       acc;
    logic       take;
    logic       hit;
    logic       ev;
    logic       lvl;
    logic       cap;
    logic [7:0] half;
    logic [7:0] rx_new;
    logic [31:0] rd_mux;

    // Register read image; unimplemented bits read zero
    always_comb begin
        unique case (paddr)
            spm_pkg::CTRL0_OFFSET: rd_mux = {24'h000000, state_reg.mode,
                3'h0, state_reg.en, state_reg.icf};
            spm_pkg::CTRL1_OFFSET: rd_mux = {24'h000000, 2'h0,
                state_reg.pol, state_reg.edge_sel, state_reg.msb,
                state_reg.csen, state_reg.wcol, state_reg.trf};
            spm_pkg::DATA_OFFSET:  rd_mux = {24'h000000, state_reg.data};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        // Pins cross into pclk through two flops; only s2 is read
        state_next.s1       = {cs_n_i, sdi_i, sck_i};
        state_next.s2       = state_reg.s1;
        state_next.sck_last = state_reg.s2[0];

        slave = state_reg.mode[spm_pkg::MODE_SLAVE_BIT];
        // Without select enable the slave is always addressed
        sel   = state_reg.csen ? !state_reg.s2[2] : 1'b1;
        busy  = state_reg.run | (state_reg.bits != 4'h0);
        half  = spm_pkg::HALF_BASE << {state_reg.mode[1:0], 1'b0};

        // APB: one wait state so read data comes from a flop
        acc  = psel & penable;
        take = acc & state_reg.pready;
        hit  = (paddr == spm_pkg::CTRL0_OFFSET) |
               (paddr == spm_pkg::CTRL1_OFFSET) |
               (paddr == spm_pkg::DATA_OFFSET);
        state_next.pready = acc & !state_reg.pready;
        if (acc && !state_reg.pready) begin
            state_next.prdata  = rd_mux;
            state_next.pslverr = !hit;
        end

        // Register writes; hardware sets below override a clear
        if (take && pwrite) begin
            unique case (paddr)
                spm_pkg::CTRL0_OFFSET: begin
                    state_next.mode = pwdata[spm_pkg::C0_MODE_LSB +: 3];
                    state_next.en   = pwdata[spm_pkg::C0_EN_BIT];
                    // Writing this flag alone never sets completion
                    state_next.icf  = pwdata[spm_pkg::C0_ICF_BIT];
                end
                spm_pkg::CTRL1_OFFSET: begin
                    state_next.pol      = pwdata[spm_pkg::C1_POL_BIT];
                    state_next.edge_sel = pwdata[spm_pkg::C1_EDGE_BIT];
                    state_next.msb      = pwdata[spm_pkg::C1_MSB_BIT];
                    state_next.csen     = pwdata[spm_pkg::C1_CSEN_BIT];
                    state_next.wcol     = pwdata[spm_pkg::C1_WCOL_BIT];
                    state_next.trf      = pwdata[spm_pkg::C1_TRF_BIT];
                end
                spm_pkg::DATA_OFFSET: begin
                    if (busy) begin
                        // Shifting byte is kept; write is dropped
                        state_next.wcol = 1'b1;
                    end else begin
                        state_next.tx       = pwdata[7:0];
                        state_next.bits     = 4'h0;
                        state_next.have_cap = 1'b0;
                        if (state_reg.en && !slave) begin
                            state_next.run   = 1'b1;
                            state_next.edges = 5'h00;
                            state_next.div   = 8'(half - 8'h01);
                        end
                    end
                end
                default: ;
            endcase
        end

        // Clock edge source: own divider or synchronised pin
        if (slave) begin
            ev  = state_reg.en && sel &&
                  (state_reg.s2[0] != state_reg.sck_last);
            lvl = state_reg.s2[0];
        end else begin
            ev  = state_reg.run && (state_reg.div == 8'h00);
            lvl = !state_reg.sck_o;
        end
        // Capture on rising when polarity equals edge select
        cap = ev && (lvl == (state_reg.pol == state_reg.edge_sel));
        rx_new = state_reg.msb ? {state_reg.rx[6:0], state_reg.s2[1]}
                               : {state_reg.s2[1], state_reg.rx[7:1]};

        // Master divider and edge count
        if (!slave && state_reg.run) begin
            if (state_reg.div == 8'h00) begin
                state_next.div   = 8'(half - 8'h01);
                state_next.sck_o = lvl;
                state_next.edges = 5'(state_reg.edges + 5'h01);
                if (state_reg.edges == spm_pkg::LAST_EDGE) begin
                    state_next.run = 1'b0;
                end
            end else begin
                state_next.div = 8'(state_reg.div - 8'h01);
            end
        end

        // Capture a bit; whole byte lands in data register at once
        if (cap) begin
            state_next.rx       = rx_new;
            state_next.have_cap = 1'b1;
            state_next.bits     = 4'(state_reg.bits + 4'h1);
            if (state_reg.bits == spm_pkg::LAST_BIT) begin
                state_next.data     = rx_new;
                state_next.trf      = 1'b1;
                state_next.bits     = 4'h0;
                state_next.have_cap = 1'b0;
            end
        end else if (ev && state_reg.have_cap) begin
            // Advance output only after a capture, so either phase works
            state_next.tx = state_reg.msb ? {state_reg.tx[6:0], 1'b0}
                                          : {1'b0, state_reg.tx[7:1]};
            state_next.have_cap = 1'b0;
        end

        // Master pulled select away mid-byte
        if (slave && state_reg.en && state_reg.csen && state_reg.s2[2] &&
            state_reg.bits != 4'h0) begin
            state_next.icf      = 1'b1;
            state_next.trf      = 1'b1;
            state_next.bits     = 4'h0;
            state_next.have_cap = 1'b0;
        end

        // Disabled port drops any transfer in flight
        if (!state_next.en) begin
            state_next.run      = 1'b0;
            state_next.bits     = 4'h0;
            state_next.have_cap = 1'b0;
        end
        if (!state_next.run) begin
            state_next.sck_o = !state_next.pol;
        end

        // Pin drives, registered; no gating here needs pclk stopping
        state_next.sck_oe = state_next.en &&
            !state_next.mode[spm_pkg::MODE_SLAVE_BIT];
        state_next.sdo_oe = state_next.en &&
            (!state_next.mode[spm_pkg::MODE_SLAVE_BIT] || sel);
        // Last bit is held one cycle past the final edge for hold time
        state_next.sdo_o  = (state_next.run || state_reg.run ||
            state_next.bits != 4'h0 ||
            (slave && state_reg.csen && !state_reg.s2[2])) ?
            (state_next.msb ? state_next.tx[7] : state_next.tx[0])
            : 1'b1;
        state_next.cs_oe  = state_next.en && state_next.csen &&
            !state_next.mode[spm_pkg::MODE_SLAVE_BIT];
        // Select falls with run, a half period before the first edge, and
        // rises a cycle after the last one so the far end keeps that bit
        state_next.cs_o   = !(state_next.run || state_reg.run);
        state_next.irq    = state_next.trf;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Runs on pclk alone, so idle modes keep it working while pclk runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign irq     = state_reg.irq;
    assign sck_o   = state_reg.sck_o;
    assign sck_oe  = state_reg.sck_oe;
    assign sdo_o   = state_reg.sdo_o;
    assign sdo_oe  = state_reg.sdo_oe;
    assign cs_n_o  = state_reg.cs_o;
    assign cs_n_oe = state_reg.cs_oe;

endmodule : spm_port
